// File: bpc_pkg.sv
// Package with the register map, field positions and reset values of the change-interrupt port.
package bpc_pkg;

	localparam int BPC_WIDTH = 8;
	localparam int BPC_MON_WIDTH = 4;
	localparam int BPC_ADDR_WIDTH = 8;

	// Register byte offsets.
	localparam logic [7:0] BPC_OFS_PORT_DATA = 8'h00;
	localparam logic [7:0] BPC_OFS_DIRECTION = 8'h04;
	localparam logic [7:0] BPC_OFS_LATCH = 8'h08;
	localparam logic [7:0] BPC_OFS_FIRST_DATA = 8'h0c;
	localparam logic [7:0] BPC_OFS_IRQ_PRIMARY = 8'h10;
	localparam logic [7:0] BPC_OFS_IRQ_TWO = 8'h14;
	localparam logic [7:0] BPC_OFS_IRQ_STATUS = 8'h18;
	localparam logic [7:0] BPC_OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] BPC_OFS_PIN_CONFIG = 8'h20;
	localparam logic [7:0] BPC_OFS_DATA_PEEK = 8'h24;
	localparam logic [7:0] BPC_OFS_FIRST_PEEK = 8'h28;

	// Field positions.
	localparam int BPC_BIT_CHANGE_FLAG = 0;
	localparam int BPC_BIT_PULLUP_DIS_N = 7;
	localparam int BPC_BIT_ANALOG2 = 0;
	localparam int BPC_BIT_ANALOG3 = 1;
	localparam int BPC_PIN_CHG2 = 2;
	localparam int BPC_PIN_CHG3 = 3;

	// Reset values.
	localparam logic [7:0] BPC_RST_DIRECTION = 8'hff;
	localparam logic [7:0] BPC_RST_LATCH = 8'h00;
	localparam logic [7:0] BPC_RST_IRQ_TWO = 8'h80;
	localparam logic [7:0] BPC_RST_MASK = 8'h00;
	localparam logic [1:0] BPC_RST_ANALOG = 2'h3;

	// Pins that may be handed to the power PWM outputs.
	localparam logic [7:0] BPC_PWM_SHAREABLE = 8'hf3;

	// Bus encodings.
	localparam logic [1:0] BPC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] BPC_HTRANS_SEQ = 2'h3;
	localparam logic [1:0] BPC_HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		BPC_CFG_WAIT = 2'b00,
		BPC_CFG_DONE = 2'b01
	} bpc_cfg_state_type;

endpackage

// File: bpc_port.sv
// Eight-pin bidirectional port with interrupt-on-change, reached over AHB-Lite.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module bpc_port
	import bpc_pkg::*;
#(
	parameter int WIDTH = bpc_pkg::BPC_WIDTH
) (
	// Bus clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [bpc_pkg::BPC_ADDR_WIDTH-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	// Port pins.
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output logic [WIDTH-1:0] pullup_en,
	// Monitored pins of the neighbouring port and their directions.
	input wire logic [1:0] first_port_pin_in,
	input wire logic [1:0] first_port_dir,
	// PWM sharing.
	input wire logic [WIDTH-1:0] pwm_out,
	input wire logic [WIDTH-1:0] pwm_select,
	// Configuration strap.
	input wire logic slow_osc_pin_select,
	// Interrupt and wake.
	output logic irq,
	output logic wake_request
);
	import bpc_pkg::*;

	function automatic logic is_data_access(input logic [BPC_ADDR_WIDTH-1:0] a);
		return (a == BPC_OFS_PORT_DATA) || (a == BPC_OFS_FIRST_DATA);
	endfunction

	logic [WIDTH-1:0] pin_meta;
	logic [WIDTH-1:0] pin_sync;
	logic [1:0] first_meta;
	logic [1:0] first_sync;
	logic strap_meta;
	logic strap_sync;
	logic [WIDTH-1:0] direction;
	logic [WIDTH-1:0] latch;
	logic [WIDTH-1:0] irq_two;
	logic [1:0] analog;
	logic [BPC_MON_WIDTH-1:0] snapshot;
	logic port_change_flag;
	logic change_mask;
	bpc_cfg_state_type cfg_state;
	logic ap_valid;
	logic wr_pending;
	logic [BPC_ADDR_WIDTH-1:0] wr_addr;
	logic [WIDTH-1:0] digital_pins;
	logic [BPC_MON_WIDTH-1:0] monitored;
	logic [BPC_MON_WIDTH-1:0] mon_enable;
	logic mismatch;
	logic refresh;
	logic flag_clear;
	logic [WIDTH-1:0] wdata8;
	logic [31:0] next_rdata;
	logic [WIDTH-1:0] analog_pins;

	assign ap_valid = hsel && hready && (htrans == BPC_HTRANS_NONSEQ || htrans == BPC_HTRANS_SEQ);
	assign wdata8 = hwdata[WIDTH-1:0];
	assign hreadyout = 1'b1;
	assign hresp = BPC_HRESP_OKAY;

	// Two-stage synchronisers for everything arriving from pins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			first_meta <= '0;
			first_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			first_meta <= first_port_pin_in;
			first_sync <= first_meta;
		end
	end

	// The strap chain has no reset, so it is already filled with the real strap level when reset
	// lets go; a cleared chain would always pick the analog default for pins 2 and 3.
	always_ff @(posedge hclk) begin
		strap_meta <= slow_osc_pin_select;
		strap_sync <= strap_meta;
	end

	// Analog pins read back as zero on the digital path.
	always_comb begin
		analog_pins = '0;
		analog_pins[BPC_PIN_CHG2] = analog[BPC_BIT_ANALOG2];
		analog_pins[BPC_PIN_CHG3] = analog[BPC_BIT_ANALOG3];
	end
	assign digital_pins = pin_sync & ~analog_pins;

	// Pin drivers, one generated slice per pin.
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_pin
			logic pwm_taken;
			assign pwm_taken = pwm_select[gi] && BPC_PWM_SHAREABLE[gi];
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_out[gi] <= 1'b0;
					pin_oe_n[gi] <= 1'b1;
					pullup_en[gi] <= 1'b0;
				end else begin
					pin_out[gi] <= pwm_taken ? pwm_out[gi] : latch[gi];
					pin_oe_n[gi] <= direction[gi] && !pwm_taken;
					// Pull-up needs the shared enable, input direction, no PWM takeover and a digital pin.
					pullup_en[gi] <= !irq_two[BPC_BIT_PULLUP_DIS_N] && direction[gi] && !pwm_taken
						&& !analog_pins[gi];
				end
			end
		end
	endgenerate

	// Strap is caught once after reset release to pick the pin 2/3 defaults.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_state <= BPC_CFG_WAIT;
		end else begin
			case (cfg_state)
				BPC_CFG_WAIT: cfg_state <= BPC_CFG_DONE;
				BPC_CFG_DONE: cfg_state <= BPC_CFG_DONE;
				default: cfg_state <= BPC_CFG_WAIT;
			endcase
		end
	end

	// Write data phase bookkeeping.
	// Writes are applied one cycle late because hwdata only stands in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr <= '0;
		end else if (hready) begin
			wr_pending <= ap_valid && hwrite;
			wr_addr <= haddr;
		end
	end

	// Direction and latch registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			direction <= BPC_RST_DIRECTION;
			latch <= BPC_RST_LATCH;
		end else if (wr_pending) begin
			if (wr_addr == BPC_OFS_DIRECTION) begin
				direction <= wdata8;
			end else if (wr_addr == BPC_OFS_LATCH || wr_addr == BPC_OFS_PORT_DATA) begin
				latch <= wdata8;
			end
		end
	end

	// Second interrupt control register holds the shared pull-up disable.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_two <= BPC_RST_IRQ_TWO;
		end else if (wr_pending && wr_addr == BPC_OFS_IRQ_TWO) begin
			irq_two <= wdata8;
		end
	end

	// Analog selection for pins 2 and 3; the default follows the strap.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog <= BPC_RST_ANALOG;
		end else if (cfg_state == BPC_CFG_WAIT) begin
			analog <= {2{!strap_sync}};
		end else if (wr_pending && wr_addr == BPC_OFS_PIN_CONFIG) begin
			analog <= wdata8[1:0];
		end
	end

	// Change mask register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			change_mask <= BPC_RST_MASK[BPC_BIT_CHANGE_FLAG];
		end else if (wr_pending && wr_addr == BPC_OFS_IRQ_MASK) begin
			change_mask <= wdata8[BPC_BIT_CHANGE_FLAG];
		end
	end

	// Monitored pins: port pins 2 and 3, then pins 0 and 1 of the neighbour.
	assign monitored = {first_sync, digital_pins[BPC_PIN_CHG3], digital_pins[BPC_PIN_CHG2]};
	assign mon_enable = {first_port_dir, direction[BPC_PIN_CHG3], direction[BPC_PIN_CHG2]};
	assign mismatch = |((monitored ^ snapshot) & mon_enable);

	// Any read or write of either data register refreshes the snapshot; the peek aliases do not.
	assign refresh = ap_valid && is_data_access(haddr);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snapshot <= '0;
		end else if (refresh) begin
			snapshot <= monitored;
		end
	end

	// Clear by writing zero to the primary register or one to the status register.
	assign flag_clear = wr_pending && ((wr_addr == BPC_OFS_IRQ_PRIMARY && !wdata8[BPC_BIT_CHANGE_FLAG])
		|| (wr_addr == BPC_OFS_IRQ_STATUS && wdata8[BPC_BIT_CHANGE_FLAG]));

	// A live mismatch wins over any clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_change_flag <= 1'b0;
		end else if (mismatch) begin
			port_change_flag <= 1'b1;
		end else if (flag_clear) begin
			port_change_flag <= 1'b0;
		end
	end

	assign irq = port_change_flag && change_mask;
	assign wake_request = port_change_flag && change_mask;

	// Read data is formed in the address phase and registered into the data phase.
	// hrdata only moves on a read, so it stands through the whole data phase.
	always_comb begin
		next_rdata = '0;
		if (haddr == BPC_OFS_PORT_DATA || haddr == BPC_OFS_DATA_PEEK) begin
			next_rdata[WIDTH-1:0] = digital_pins;
		end else if (haddr == BPC_OFS_DIRECTION) begin
			next_rdata[WIDTH-1:0] = direction;
		end else if (haddr == BPC_OFS_LATCH) begin
			next_rdata[WIDTH-1:0] = latch;
		end else if (haddr == BPC_OFS_FIRST_DATA || haddr == BPC_OFS_FIRST_PEEK) begin
			next_rdata[1:0] = first_sync;
		end else if (haddr == BPC_OFS_IRQ_PRIMARY || haddr == BPC_OFS_IRQ_STATUS) begin
			next_rdata[BPC_BIT_CHANGE_FLAG] = port_change_flag;
		end else if (haddr == BPC_OFS_IRQ_TWO) begin
			next_rdata[WIDTH-1:0] = irq_two;
		end else if (haddr == BPC_OFS_IRQ_MASK) begin
			next_rdata[BPC_BIT_CHANGE_FLAG] = change_mask;
		end else if (haddr == BPC_OFS_PIN_CONFIG) begin
			next_rdata[1:0] = analog;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (ap_valid && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// Assertions.
	a_dir_floats: assert property (@(posedge hclk) disable iff (!hresetn)
		(direction[0] && !pwm_select[0]) |=> pin_oe_n[0])
		else $error("input pin is being driven");
	a_latch_drives: assert property (@(posedge hclk) disable iff (!hresetn)
		(!direction[5] && !pwm_select[5]) |=> (!pin_oe_n[5] && pin_out[5] == $past(latch[5])))
		else $error("output pin does not show latch");
	a_latch_readback: assert property (@(posedge hclk) disable iff (!hresetn)
		(ap_valid && !hwrite && haddr == BPC_OFS_LATCH) |=> hrdata[WIDTH-1:0] == $past(latch))
		else $error("latch read returned something else");
	a_pullup_output: assert property (@(posedge hclk) disable iff (!hresetn)
		!direction[1] |=> !pullup_en[1])
		else $error("pull-up on output pin");
	a_pullup_shared: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_two[BPC_BIT_PULLUP_DIS_N] |=> pullup_en == '0)
		else $error("pull-up active while disabled");
	a_reset_dir: assert property (@(posedge hclk)
		$rose(hresetn) |-> (direction == BPC_RST_DIRECTION && irq_two[BPC_BIT_PULLUP_DIS_N]))
		else $error("reset state wrong");
	a_strap_analog: assert property (@(posedge hclk) disable iff (!hresetn)
		(cfg_state == BPC_CFG_WAIT) |=> analog == {2{!$past(strap_sync)}})
		else $error("strap default not applied");
	a_pwm_excluded: assert property (@(posedge hclk) disable iff (!hresetn)
		(pwm_select[2] && !direction[2]) |=> pin_out[2] == $past(latch[2]))
		else $error("pin two taken by pwm");
	a_output_excluded: assert property (@(posedge hclk) disable iff (!hresetn)
		(mon_enable == '0) |-> !mismatch)
		else $error("output pin caused change");
	a_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		mismatch |=> port_change_flag)
		else $error("mismatch did not set flag");
	a_refresh_ends: assert property (@(posedge hclk) disable iff (!hresetn)
		(refresh ##1 $stable(monitored)) |-> !mismatch)
		else $error("refresh did not end mismatch");
	a_clear_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
		(flag_clear && mismatch) |=> port_change_flag)
		else $error("clear won over live mismatch");
	a_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		(port_change_flag && change_mask) |-> (wake_request && irq))
		else $error("no wake on change");

	// Register writes land in the data phase; reads return what each address promises.
	a_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == BPC_OFS_DIRECTION) |=> direction == $past(wdata8))
		else $error("direction write lost");
	a_latch_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == BPC_OFS_LATCH) |=> latch == $past(wdata8))
		else $error("latch write lost");
	a_data_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == BPC_OFS_PORT_DATA) |=> latch == $past(wdata8))
		else $error("data write did not reach latch");
	a_data_readback: assert property (@(posedge hclk) disable iff (!hresetn)
		(ap_valid && !hwrite && haddr == BPC_OFS_PORT_DATA) |=> hrdata[WIDTH-1:0] == $past(digital_pins))
		else $error("data read did not return pins");
	a_reset_pins: assert property (@(posedge hclk)
		$rose(hresetn) |-> (pin_oe_n == '1 && pullup_en == '0))
		else $error("pins not inputs after reset");
	a_pullup_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(!irq_two[BPC_BIT_PULLUP_DIS_N] && direction[6] && !pwm_select[6]) |=> pullup_en[6])
		else $error("pull-up missing on input pin");
	a_analog_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		analog[BPC_BIT_ANALOG3] |-> !digital_pins[BPC_PIN_CHG3])
		else $error("analog pin read as digital");
	a_pwm_drives: assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_select[4] |=> (!pin_oe_n[4] && pin_out[4] == $past(pwm_out[4])))
		else $error("pwm did not take pin four");

	// Change detection: snapshot, compare, sticky flag and its clear.
	a_snapshot_take: assert property (@(posedge hclk) disable iff (!hresetn)
		refresh |=> snapshot == $past(monitored))
		else $error("snapshot not refreshed");
	a_peek_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
		(ap_valid && (haddr == BPC_OFS_DATA_PEEK || haddr == BPC_OFS_FIRST_PEEK)) |=> $stable(snapshot))
		else $error("peek access refreshed snapshot");
	a_change_seen: assert property (@(posedge hclk) disable iff (!hresetn)
		(mon_enable[0] && monitored[0] != snapshot[0]) |-> mismatch)
		else $error("input change not detected");
	a_clear_works: assert property (@(posedge hclk) disable iff (!hresetn)
		(flag_clear && !mismatch) |=> !port_change_flag)
		else $error("clear without mismatch ignored");
	a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		(port_change_flag && !flag_clear) |=> port_change_flag)
		else $error("flag dropped without clear");
	a_mask_gates: assert property (@(posedge hclk) disable iff (!hresetn)
		!change_mask |-> (!irq && !wake_request))
		else $error("masked change raised interrupt");

	c_change_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
	c_refresh_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		port_change_flag ##1 refresh ##[1:5] flag_clear ##1 !port_change_flag);
	c_pullup_on: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pullup_en[7]));
	c_pwm_use: cover property (@(posedge hclk) disable iff (!hresetn) pwm_select[4] && !pin_oe_n[4]);
	c_strap_digital: cover property (@(posedge hclk) disable iff (!hresetn) cfg_state == BPC_CFG_WAIT && strap_sync);

endmodule

// File: bpc_pin_env.sv
// Outside world of the port pins: resolves each pad from the port, outside drivers and pull-ups.
`timescale 1ns/1ns
module bpc_pin_env (
	// Clock.
	input wire logic clk,
	// Port side.
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pullup_en,
	// Outside drivers.
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Resolved pad levels.
	output logic [7:0] pad
);
	logic [7:0] float_val = 8'h55;

	// A pad nobody drives or pulls up wanders every cycle, so a stale level never passes for data.
	always @(posedge clk) begin
		float_val <= ~float_val;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i])
				pad[i] = pin_out[i];
			else if (ext_en[i])
				pad[i] = ext_val[i];
			else if (pullup_en[i])
				pad[i] = 1'b1;
			else
				pad[i] = float_val[i];
		end
	end
endmodule

// File: bidir_port_with_change_irq_bench.sv
// Self-checking bench for the change-interrupt port, driven over AHB-Lite.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); end end
module bidir_port_with_change_irq_bench;
	import bpc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hready;
	logic hreadyout, irq, wake_request;
	logic [1:0] hresp;
	logic [31:0] hrdata, junk;
	logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en;
	logic [7:0] ext_val = 8'h8e;
	logic [7:0] ext_en = 8'hcf;
	logic [7:0] pwm_out = 8'h00;
	logic [7:0] pwm_select = 8'h00;
	logic [1:0] fp_in = 2'h0;
	logic [1:0] fp_dir = 2'h3;
	logic strap = 1'b0;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	assign hready = hreadyout;
	always #50 hclk = ~hclk;

	bpc_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pullup_en(pullup_en), .first_port_pin_in(fp_in), .first_port_dir(fp_dir), .pwm_out(pwm_out),
		.pwm_select(pwm_select), .slow_osc_pin_select(strap), .irq(irq), .wake_request(wake_request));

	bpc_pin_env u_env (.clk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
		.ext_val(ext_val), .ext_en(ext_en), .pad(pin_in));

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end

	// One single word transfer; the answer is taken at the edge that samples hready.
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= BPC_HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, junk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 8'h00, r);
		`CHK(r, {24'h0, e})
	endtask

	// Both port reads renew the snapshot, then the flag is cleared both ways.
	task automatic refresh_clear();
		bus(BPC_OFS_PORT_DATA, 1'b0, 8'h00, junk);
		bus(BPC_OFS_FIRST_DATA, 1'b0, 8'h00, junk);
		wr(BPC_OFS_IRQ_STATUS, 8'h01);
		wr(BPC_OFS_IRQ_PRIMARY, 8'h00);
	endtask

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		`CHK(pin_oe_n, 8'hff)
		`CHK(pullup_en, 8'h00)
		`CHK(hresp, BPC_HRESP_OKAY)
		rd_chk(BPC_OFS_DIRECTION, 8'hff);
		rd_chk(BPC_OFS_IRQ_TWO, 8'h80);
		rd_chk(BPC_OFS_PIN_CONFIG, 8'h03);
		rd_chk(BPC_OFS_IRQ_MASK, 8'h00);
		rd_chk(8'h3c, 8'h00);
		wr(BPC_OFS_PIN_CONFIG, 8'h00);
		wr(BPC_OFS_DIRECTION, 8'hcf);
		wr(BPC_OFS_LATCH, 8'h5a);
		repeat (2) @(posedge hclk);
		`CHK(pin_oe_n, 8'hcf)
		`CHK(pin_out & 8'h30, 8'h10)
		rd_chk(BPC_OFS_LATCH, 8'h5a);
		rd_chk(BPC_OFS_PORT_DATA, 8'h10 | (8'h8e & 8'hcf));
		wr(BPC_OFS_PORT_DATA, 8'h21);
		rd_chk(BPC_OFS_LATCH, 8'h21);
		wr(BPC_OFS_IRQ_TWO, 8'h00);
		repeat (2) @(posedge hclk);
		`CHK(pullup_en, 8'hcf)
		wr(BPC_OFS_IRQ_TWO, 8'h80);
		repeat (2) @(posedge hclk);
		`CHK(pullup_en, 8'h00)
		wr(BPC_OFS_IRQ_MASK, 8'h01);
		for (int i = 0; i < 4; i++) begin
			refresh_clear();
			`CHK(irq, 1'b0)
			if (i < 2)
				ext_val[2 + i] <= ~ext_val[2 + i];
			else
				fp_in[i - 2] <= ~fp_in[i - 2];
			repeat (6) @(posedge hclk);
			rd_chk(BPC_OFS_IRQ_PRIMARY, 8'h01);
			`CHK({irq, wake_request}, 2'b11)
			wr(BPC_OFS_IRQ_STATUS, 8'h01);
			rd_chk(BPC_OFS_IRQ_STATUS, 8'h01);
			bus((i < 2) ? BPC_OFS_DATA_PEEK : BPC_OFS_FIRST_PEEK, 1'b0, 8'h00, junk);
			wr(BPC_OFS_IRQ_STATUS, 8'h01);
			rd_chk(BPC_OFS_IRQ_STATUS, 8'h01);
			refresh_clear();
			rd_chk(BPC_OFS_IRQ_STATUS, 8'h00);
		end
		fp_dir <= 2'b01;
		refresh_clear();
		fp_in[1] <= ~fp_in[1];
		repeat (6) @(posedge hclk);
		rd_chk(BPC_OFS_IRQ_STATUS, 8'h00);
		wr(BPC_OFS_IRQ_MASK, 8'h00);
		ext_val[3] <= ~ext_val[3];
		repeat (6) @(posedge hclk);
		rd_chk(BPC_OFS_IRQ_STATUS, 8'h01);
		`CHK({irq, wake_request}, 2'b00)
		pwm_out <= 8'ha5;
		pwm_select <= 8'hff;
		repeat (3) @(posedge hclk);
		`CHK(pin_out & 8'hf3, 8'ha5 & 8'hf3)
		`CHK(pin_oe_n, 8'h0c)
		wr(BPC_OFS_DIRECTION, 8'hcb);
		repeat (2) @(posedge hclk);
		`CHK(pin_oe_n, 8'h08)
		`CHK(pin_out & 8'h0c, 8'h21 & 8'h0c)
		// Second reset with the strap set: pins 2 and 3 must come up digital.
		strap <= 1'b1;
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd_chk(BPC_OFS_PIN_CONFIG, 8'h00);
		rd_chk(BPC_OFS_DIRECTION, 8'hff);
		rd_chk(BPC_OFS_IRQ_TWO, 8'h80);
		end_of_test();
	end
endmodule
